// *** verilog/vdat_pkg.sv ***
// Package for the video DRAM access sequencer: timing counts and carriers.
// Assumes a single 200 MHz processor clock; counts are in clock cycles.
package vdat_pkg;

  // Initial access latencies, in cycles from request to first word
  localparam int VDAT_INSTR_LAT      = 6;
  localparam int VDAT_READ_LAT       = 5;
  localparam int VDAT_WRITE_LAT_FAST = 3;
  localparam int VDAT_WRITE_LAT_SLOW = 4;
  // Refresh period and length
  localparam int VDAT_REFRESH_PERIOD = 390;
  localparam int VDAT_REFRESH_LEN    = 6;
  // Precharge between accesses; idle cycle overlaps one of them
  localparam int VDAT_PRECHARGE      = 3;
  localparam int VDAT_PRE_GAP        = VDAT_PRECHARGE - 1;
  // Extra hold-off after a data write
  localparam int VDAT_WRITE_RECOVERY = 3;

  localparam int VDAT_AW = 24;

  // Request from the processor side
  typedef struct packed {
    logic              valid;
    logic              instr;   // Instruction fetch
    logic              write;   // Data write (ignored for instr)
    logic              burst;   // Burst request on the data bus
    logic [VDAT_AW-1:0] addr;
  } vdat_req_t;

  // Control toward the memory array
  typedef struct packed {
    logic              row_strobe;   // Random port row/column cycle active
    logic              xfer;         // Row transfer to the shifter
    logic              shift;        // Shift one word out of the serial port
    logic              wr_en;
    logic              refresh;
    logic [VDAT_AW-1:0] addr;
  } vdat_mem_t;

endpackage

// *** verilog/vdat_refresh_timer.sv ***
// Free-running refresh interval counter.
// Assumes the sequencer acknowledges each due pulse when it starts a refresh.
`timescale 1ns/10ps
module vdat_refresh_timer
#(
  parameter int PERIOD = vdat_pkg::VDAT_REFRESH_PERIOD
)
(
  input  wire logic clock,   // Processor clock
  input  wire logic rst_n,   // Synchronous reset, active low
  input  wire logic ack,     // Refresh started
  output logic      due      // Refresh is pending
);
  import vdat_pkg::*;

  localparam int CW = $clog2(PERIOD);
  logic [CW-1:0] cnt_reg;
  logic          due_reg;
  wire           wrap = (cnt_reg == CW'(PERIOD - 1));

  // Count every cycle; flag a refresh at each wrap, wrap wins over ack
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      due_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      due_reg <= wrap | (due_reg & ~ack);
    end
  end

  assign due = due_reg;
endmodule

// *** verilog/vdat_burst_shifter.sv ***
// Serial port burst engine: one instruction word per cycle after start.
// Assumes start is a one-cycle pulse in the cycle the row transfer is issued.
`timescale 1ns/10ps
module vdat_burst_shifter
(
  input  wire logic clock,   // Processor clock
  input  wire logic rst_n,   // Synchronous reset, active low
  input  wire logic start,   // Begin streaming
  input  wire logic stop,    // Burst ended by a new request
  output logic      active,  // Streaming
  output logic      shift    // Shift strobe this cycle
);
  import vdat_pkg::*;

  logic act_reg;

  // Runs independently of the random port until told to stop
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      act_reg <= 1'b0;
    else if (stop)
      act_reg <= 1'b0;
    else if (start)
      act_reg <= 1'b1;
  end

  assign active = act_reg;
  assign shift  = act_reg & ~stop;
endmodule

// *** verilog/vdat_sequencer.sv ***
// Access sequencer for a shared video DRAM serving instruction and data buses.
// Assumes one processor clock, requests held until ready, one memory block.
`timescale 1ns/10ps
module vdat_sequencer
#(
  parameter bit SLOW_WRITE = 1'b1   // Fitted parts need the four-cycle write
)
(
  input  wire logic                clock,     // Processor clock, 200 MHz
  input  wire logic                rst_n,     // Synchronous reset, active low
  input  wire vdat_pkg::vdat_req_t req,       // Processor request
  output vdat_pkg::vdat_mem_t      mem,       // Memory array control
  output logic                     req_ready, // Request accepted (pulse)
  output logic                     rdy,       // Word done/valid (pulse)
  output logic                     burst_err, // Data burst refused (pulse)
  output logic                     busy       // Sequencer not idle
);
  import vdat_pkg::*;

  typedef enum logic [2:0] {
    VDAT_IDLE, VDAT_PRE, VDAT_ACCESS, VDAT_WREC, VDAT_REFRESH
  } vdat_state_t;

  localparam int WR_LAT = SLOW_WRITE ? VDAT_WRITE_LAT_SLOW : VDAT_WRITE_LAT_FAST;

  vdat_state_t        state_reg, state_next;
  logic [3:0]         cnt_reg, cnt_next;
  logic [3:0]         gap_reg;            // Cycles since random port closed
  logic               kind_instr_reg, kind_write_reg;
  logic [VDAT_AW-1:0] addr_reg;
  vdat_mem_t          mem_reg, mem_next;
  logic               ready_reg, rdy_reg, err_reg, busy_reg;
  logic               ref_ack;
  wire                ref_due;
  wire                sh_active;
  wire                sh_shift;

  vdat_refresh_timer #(.PERIOD(VDAT_REFRESH_PERIOD)) u_timer
  (
    .clock (clock),
    .rst_n (rst_n),
    .ack   (ref_ack),
    .due   (ref_due)
  );

  // Decode of the incoming request
  wire new_req     = req.valid & ~ready_reg;
  wire is_instr    = new_req & req.instr;
  wire is_data     = new_req & ~req.instr;
  wire data_burst  = is_data & req.burst;
  // Precharge met if closed long enough; idle cycle is the last one
  wire pre_ok      = (gap_reg >= 4'(VDAT_PRE_GAP));
  // Any new request ends a running instruction burst
  wire burst_stop  = sh_active & new_req & (state_reg == VDAT_IDLE);
  wire access_done = (state_reg == VDAT_ACCESS) && (cnt_reg == 4'd1);
  wire xfer_start  = access_done & kind_instr_reg;

  vdat_burst_shifter u_shift
  (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (xfer_start),
    .stop   (burst_stop),
    .active (sh_active),
    .shift  (sh_shift)
  );

  // Latency loaded at acceptance; idle decode cycle counts as the first
  function automatic logic [3:0] lat_of(input logic instr, input logic write);
    if (instr)
      lat_of = 4'(VDAT_INSTR_LAT - 1);
    else if (write)
      lat_of = 4'(WR_LAT - 1);
    else
      lat_of = 4'(VDAT_READ_LAT - 1);
  endfunction

  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    mem_next   = mem_reg;
    ref_ack    = 1'b0;
    mem_next.shift   = sh_shift;
    mem_next.xfer    = 1'b0;
    mem_next.refresh = 1'b0;
    unique case (state_reg)
      VDAT_IDLE:
      begin
        mem_next.row_strobe = 1'b0;
        mem_next.wr_en      = 1'b0;
        if (ref_due && pre_ok)
        begin
          // Refresh beats new requests; burst keeps shifting unless a new request arrives this cycle
          ref_ack          = 1'b1;
          mem_next.refresh = 1'b1;
          state_next       = VDAT_REFRESH;
          cnt_next         = 4'(VDAT_REFRESH_LEN);
        end
        else if (new_req && !data_burst)
        begin
          if (pre_ok)
          begin
            state_next = VDAT_ACCESS;
            cnt_next   = lat_of(req.instr, req.write);
            mem_next.row_strobe = 1'b1;
            mem_next.wr_en      = ~req.instr & req.write;
            mem_next.addr       = req.addr;
          end
          else
            state_next = VDAT_PRE;
        end
      end
      VDAT_PRE:
      begin
        // Wait out remaining precharge, then decode again
        if (pre_ok)
          state_next = VDAT_IDLE;
      end
      VDAT_ACCESS:
      begin
        cnt_next = cnt_reg - 4'd1;
        if (access_done)
        begin
          mem_next.row_strobe = 1'b0;
          mem_next.xfer       = kind_instr_reg;
          mem_next.wr_en      = 1'b0;
          if (kind_write_reg)
          begin
            state_next = VDAT_WREC;
            cnt_next   = 4'(VDAT_WRITE_RECOVERY);
          end
          else
            state_next = VDAT_IDLE;
        end
      end
      VDAT_WREC:
      begin
        cnt_next = cnt_reg - 4'd1;
        if (cnt_reg == 4'd1)
          state_next = VDAT_IDLE;
      end
      VDAT_REFRESH:
      begin
        // Requests held off until refresh finishes
        mem_next.refresh = (cnt_reg != 4'd1);
        cnt_next         = cnt_reg - 4'd1;
        if (cnt_reg == 4'd1)
          state_next = VDAT_IDLE;
      end
    endcase
  end

  // Acceptance strobes
  wire accept = (state_reg == VDAT_IDLE) && !(ref_due && pre_ok) && new_req && pre_ok;
  wire refuse = (state_reg == VDAT_IDLE) && !(ref_due && pre_ok) && data_burst;

  // State and counters
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= VDAT_IDLE;
      cnt_reg   <= '0;
      gap_reg   <= 4'(VDAT_PRE_GAP);
      mem_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      mem_reg   <= mem_next;
      // Random port closed time, saturating
      if (mem_next.row_strobe || mem_next.refresh || state_next == VDAT_WREC)
        gap_reg <= '0;
      else if (gap_reg != 4'hf)
        gap_reg <= gap_reg + 4'd1;
    end
  end

  // Captured request kind and handshake outputs
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      kind_instr_reg <= 1'b0;
      kind_write_reg <= 1'b0;
      addr_reg       <= '0;
      ready_reg      <= 1'b0;
      rdy_reg        <= 1'b0;
      err_reg        <= 1'b0;
      busy_reg       <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        kind_instr_reg <= req.instr;
        kind_write_reg <= ~req.instr & req.write;
        addr_reg       <= req.addr;
      end
      ready_reg <= accept | refuse;
      err_reg   <= refuse;
      rdy_reg   <= access_done | sh_shift;
      busy_reg  <= (state_next != VDAT_IDLE);
    end
  end

  assign mem       = mem_reg;
  assign req_ready = ready_reg;
  assign rdy       = rdy_reg;
  assign burst_err = err_reg;
  assign busy      = busy_reg;
endmodule

// *** verif/vdat_monitor.sv ***
// Port timing checker for the access sequencer.
// Assumes one clock and requests held until req_ready.
`timescale 1ns/10ps
module vdat_monitor
#(
  parameter bit SLOW_WRITE = 1'b1 // Four-cycle write parts
)
(
  input wire logic                clock,     // Processor clock
  input wire logic                rst_n,     // Synchronous reset, active low
  input wire vdat_pkg::vdat_req_t req,       // Processor request
  input wire vdat_pkg::vdat_mem_t mem,       // Memory array control
  input wire logic                req_ready, // Request accepted
  input wire logic                rdy,       // Word done
  input wire logic                burst_err, // Data burst refused
  input wire logic                busy       // Not idle
);
  import vdat_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Accepted access, kind taken from the held request
  wire take = req_ready && !burst_err;
  a_read_latency: assert property (take && !req.instr && !req.write |-> ##1 !rdy [*3] ##1 rdy)
    else $error("read word not on time");
  a_instr_latency: assert property (take && req.instr |-> ##1 !rdy [*4] ##1 rdy && mem.xfer)
    else $error("instruction word not on time");
  a_write_latency: assert property (take && !req.instr && req.write |-> if (SLOW_WRITE) ##3 rdy else ##2 rdy)
    else $error("write not on time");
  a_burst_refused: assert property (burst_err |-> req_ready && req.burst && !req.instr ##1 !mem.row_strobe [*5])
    else $error("data burst not refused");
  a_refresh_length: assert property ($rose(mem.refresh) |-> mem.refresh [*6] ##1 !mem.refresh)
    else $error("refresh length wrong");
  a_refresh_holdoff: assert property (mem.refresh |=> !req_ready || burst_err)
    else $error("request taken during refresh");
  a_precharge_gap: assert property ($fell(mem.row_strobe) |-> !mem.row_strobe [*2])
    else $error("precharge gap too short");
  a_burst_stream: assert property (mem.shift |-> rdy ##1 (mem.shift || req.valid))
    else $error("burst word missing");
  c_refused: cover property (burst_err);
  c_refresh_burst: cover property ($rose(mem.refresh) && mem.shift);
  c_write: cover property (take && req.write && busy);
endmodule

bind vdat_sequencer vdat_monitor #(.SLOW_WRITE(SLOW_WRITE)) mon
(
  .clock(clock), .rst_n(rst_n), .req(req), .mem(mem),
  .req_ready(req_ready), .rdy(rdy), .burst_err(burst_err), .busy(busy)
);

// *** verif/vdat_proc_model.sv ***
// Processor side model: presents one request and holds it until accepted.
// Assumes the bench pulses start for one cycle at a falling edge.
`timescale 1ns/10ps
module vdat_proc_model
(
  input  wire logic                clock,     // Processor clock
  input  wire logic                rst_n,     // Synchronous reset, active low
  input  wire logic                start,     // Present cmd now
  input  wire vdat_pkg::vdat_req_t cmd,       // Request to present
  input  wire logic                req_ready, // Request accepted
  output vdat_pkg::vdat_req_t      req        // Request to the sequencer
);
  import vdat_pkg::*;
  vdat_req_t held_reg = '0;
  vdat_req_t held_next;
  // A request stays until accepted; only the next one ends a burst
  assign req = start ? cmd : held_reg;
  // Drop valid after acceptance; released address lines do not hold
  // Kind fields stay put so the checker can read them while req_ready stands
  always @(negedge clock)
  begin
    held_next = start ? cmd : held_reg;
    if (!rst_n)
      held_next.valid = 1'b0;
    else if (held_next.valid && req_ready)
    begin
      held_next.valid = 1'b0;
      held_next.addr  = ~held_next.addr;
    end
    held_reg <= held_next;
  end
endmodule

// *** verif/tb_video_dram_access_timing.sv ***
// Self-checking bench for the access sequencer with a processor model.
// Assumes the four-cycle write build and the bench driving at falling edges.
`timescale 1ns/10ps
module tb_video_dram_access_timing;
  import vdat_pkg::*;
  localparam int BASE = 1; // Start edge to req_ready when nothing stalls
  logic      clock = 1'b0;
  logic      rst_n = 1'b0;
  logic      start = 1'b0;
  vdat_req_t cmd   = '0;
  vdat_req_t req;
  vdat_mem_t mem;
  logic      req_ready, rdy, burst_err, busy;
  int        miscompares = 0;
  int        checks      = 0;
  int        cyc         = 0;
  // Clock and cycle count
  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  vdat_sequencer #(.SLOW_WRITE(1'b1)) dut
  (
    .clock(clock), .rst_n(rst_n), .req(req), .mem(mem),
    .req_ready(req_ready), .rdy(rdy), .burst_err(burst_err), .busy(busy)
  );
  vdat_proc_model proc
  (
    .clock(clock), .rst_n(rst_n), .start(start), .cmd(cmd), .req_ready(req_ready), .req(req)
  );
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Present one request; t0 is the start cycle, tr the req_ready cycle
  task automatic issue(input logic i, input logic w, input logic b, output int t0, output int tr);
    int n;
    n = 0;
    cmd <= {1'b1, i, w, b, 24'h000100};
    start <= 1'b1;
    t0 = cyc;
    @(negedge clock);
    start <= 1'b0;
    while (req_ready !== 1'b1 && n < 60)
    begin
      @(negedge clock);
      n++;
    end
    tr = cyc;
  endtask
  // Wait for the next word strobe
  task automatic wait_rdy(output int t);
    int n;
    n = 0;
    do @(negedge clock); while (rdy !== 1'b1 && ++n < 60);
    t = cyc;
  endtask
  // Count cycles and words until refresh reaches the given level
  task automatic run_until(input logic lvl, output int m, output int n);
    m = 0;
    n = 0;
    while (mem.refresh !== lvl && m < 600)
    begin
      @(negedge clock);
      m++;
      n += (rdy === 1'b1);
    end
  endtask
  // Read, stalled write, read behind the write
  task automatic t_access();
    int t0, tr, t;
    check("busy idle", 0, 32'(busy));
    issue(1'b0, 1'b0, 1'b0, t0, tr);
    check("idle start", BASE, tr - t0);
    check("row address", 32'h000100, 32'(mem.addr));
    wait_rdy(t);
    check("read latency", VDAT_READ_LAT - 1, t - tr);
    issue(1'b0, 1'b1, 1'b0, t0, tr);
    check("stall", 1, 32'(tr - t0 > BASE));
    check("write enable", 1, 32'(mem.wr_en));
    wait_rdy(t);
    check("write latency", VDAT_WRITE_LAT_SLOW - 1, t - tr);
    issue(1'b0, 1'b0, 1'b0, t0, tr);
    check("recovery", 1, 32'(tr - t0 <= BASE + VDAT_PRE_GAP + VDAT_WRITE_RECOVERY));
    wait_rdy(t);
  endtask
  // Data burst request is refused with no access
  task automatic t_refuse();
    int t0, tr, m, n;
    repeat (3) @(negedge clock);
    issue(1'b0, 1'b0, 1'b1, t0, tr);
    check("burst refused", 1, 32'(burst_err));
    m = 0;
    n = 0;
    repeat (8)
    begin
      @(negedge clock);
      n += (rdy !== 1'b0);
    end
    check("refused words", 0, n);
  endtask
  // Instruction bursts streaming through two refresh sequences
  task automatic t_burst_refresh();
    int t0, tr, t, f1, m, n;
    issue(1'b1, 1'b0, 1'b0, t0, tr);
    check("instr start", BASE, tr - t0);
    wait_rdy(t);
    check("instr latency", VDAT_INSTR_LAT - 1, t - tr);
    run_until(1'b1, m, n);
    check("burst words", m, n);
    check("shift in refresh", 1, 32'(mem.shift));
    f1 = cyc;
    issue(1'b1, 1'b0, 1'b0, t0, tr);
    check("held off", 1, 32'(tr > f1 + VDAT_REFRESH_LEN));
    wait_rdy(t);
    run_until(1'b1, m, n);
    check("refresh period", VDAT_REFRESH_PERIOD, cyc - f1);
    run_until(1'b0, m, n);
    check("refresh length", VDAT_REFRESH_LEN, m);
    check("words in refresh", m, n);
    issue(1'b0, 1'b0, 1'b0, t0, tr);
    wait_rdy(t);
    check("read after burst", VDAT_READ_LAT - 1, t - tr);
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(negedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    t_access();
    t_refuse();
    t_burst_refresh();
    results();
  end
  // Watchdog well beyond the expected run of about eight hundred cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    miscompares++;
    results();
  end
endmodule
